// ---- design/uit_pkg.sv ----
// Purpose: Shared constants for the UART test register block
// Assumes: Word-aligned register offsets on the peripheral bus
// Notes:   Widths and resets are fixed, not tunable

package uit_pkg;

	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [11:0] OFS_TEST_CONTROL = 12'h080;
	localparam logic [11:0] OFS_INTEG_INPUT  = 12'h084;
	localparam logic [11:0] OFS_INTEG_OUTPUT = 12'h088;
	localparam logic [11:0] OFS_FIFO_TEST    = 12'h08C;

	// Register widths
	localparam int TCR_W = 3;
	localparam int ITI_W = 8;
	localparam int ITO_W = 14;
	localparam int TDR_W = 11;

	// Register reset values
	localparam logic [2:0]  TCR_RST = 3'h0;
	localparam logic [1:0]  ITI_RST = 2'h0;
	localparam logic [13:0] ITO_RST = 14'h0000;
	localparam logic [10:0] TDR_RST = 11'h000;

	// Test control fields
	localparam int TCR_INTEGRATION_TEST_ENABLE_BIT  = 0;
	localparam int TCR_FIFO_BIT  = 1;
	localparam int TCR_IRTST_BIT = 2;

	// Integration input fields
	localparam int ITI_TXCLR_BIT = 7;
	localparam int ITI_RXCLR_BIT = 6;
	localparam int ITI_PIN_HI    = 5;
	localparam int NUM_PINS      = 6;

	// Integration output split: intra-chip above, primary below
	localparam int ITO_INTRA_LO = 6;

	// Synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 2;

endpackage

// ---- design/uit_sync_if.sv ----
// Purpose: Carries synchronised primary inputs between the pin stage
//          and the register block
// Assumes: Single clock domain core_clk
// Notes:   Bit order matches integration input bits 5..0

`timescale 1ns/1ps

interface uit_sync_if;
	import uit_pkg::*;

	logic [NUM_PINS-1:0] pins_sync;

	modport src
	(
		output pins_sync
	);

	modport dst
	(
		input  pins_sync
	);

endinterface

// ---- design/uit_pin_sync.sv ----
// Purpose: Two-flop synchronisers for the six primary input pins
// Assumes: Pins are asynchronous to core_clk
// Notes:   First stage is read only by the second stage

`timescale 1ns/1ps

module uit_pin_sync
	import uit_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                nrst,
	input  wire logic [NUM_PINS-1:0] pins_raw,
	uit_sync_if.src                  sync
);

	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++)
		begin : g_bit
			logic [SYNC_STAGES-1:0] stage_q;
			logic [SYNC_STAGES-1:0] stage_d;

			always_comb
			begin
				stage_d = {stage_q[SYNC_STAGES-2:0], pins_raw[g]};
			end

			always_ff @(posedge core_clk)
			begin
				if (!nrst)
					stage_q <= '0;
				else
					stage_q <= stage_d;
			end

			assign sync.pins_sync[g] = stage_q[SYNC_STAGES-1];
		end
	endgenerate

endmodule

// ---- design/uit_test_regs.sv ----
// Purpose: Test register block of a UART: test control, integration
//          input and output, and the FIFO test data path
// Assumes: Peripheral bus slave with setup and access phases, no wait
//          states; register data in the low bits of a 32-bit word
// Notes:   Read data is registered in the setup phase so it is stable
//          for the whole access phase

`timescale 1ns/1ps

module uit_test_regs
	import uit_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              nrst,
	// Peripheral bus slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	// Primary input pins, order: ring, carrier, cts, dsr, ir in, rx data
	input  wire logic              ring_indicator_n,
	input  wire logic              carrier_detect_n,
	input  wire logic              clear_to_send_n,
	input  wire logic              data_set_ready_n,
	input  wire logic              infrared_serial_in,
	input  wire logic              serial_receive_data,
	// Intra-chip DMA clear inputs and their internal lines
	input  wire logic              tx_dma_clear,
	input  wire logic              rx_dma_clear,
	output logic                   tx_dma_clear_int,
	output logic                   rx_dma_clear_int,
	// Functional outputs from the UART core and their muxed versions
	input  wire logic [ITO_W-1:0]  core_out_func,
	output logic      [ITO_W-1:0]  core_out_mux,
	// Infrared receive gating
	input  wire logic              infrared_tx_active,
	output logic                   infrared_rx_enable,
	// Mode levels towards the UART core
	output logic                   integration_test_enable,
	output logic                   fifo_test_enable,
	output logic                   infrared_test_enable,
	// FIFO test path
	output logic                   rx_fifo_push,
	output logic      [TDR_W-1:0]  rx_fifo_push_data,
	output logic                   tx_fifo_pop,
	input  wire logic [TDR_W-1:0]  tx_fifo_head
);

	uit_sync_if sync_if ();

	uit_pin_sync u_pin_sync
	(
		.core_clk (core_clk),
		.nrst     (nrst),
		.pins_raw ({ring_indicator_n, carrier_detect_n, clear_to_send_n,
			data_set_ready_n, infrared_serial_in, serial_receive_data}),
		.sync     (sync_if.src)
	);

	// Word compare on the register offset; low two bits ignored
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [11:0] ofs);
		hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
	endfunction

	// Bus phases
	logic setup_rd;
	logic access_wr;
	logic access_rd;

	assign setup_rd  = psel && !penable && !pwrite;
	assign access_wr = psel && penable && pwrite;
	assign access_rd = psel && penable && !pwrite;

	// Register select, shared by the read and pop paths
	logic sel_tcr;
	logic sel_iti;
	logic sel_ito;
	logic sel_tdr;

	always_comb
	begin
		sel_tcr = hit(paddr, OFS_TEST_CONTROL);
		sel_iti = hit(paddr, OFS_INTEG_INPUT);
		sel_ito = hit(paddr, OFS_INTEG_OUTPUT);
		sel_tdr = hit(paddr, OFS_FIFO_TEST);
	end

	// Register state
	logic [TCR_W-1:0]  tcr_q;
	logic [TCR_W-1:0]  tcr_d;
	logic [1:0]        iti_q;
	logic [1:0]        iti_d;
	logic [ITO_W-1:0]  ito_q;
	logic [ITO_W-1:0]  ito_d;
	logic [TDR_W-1:0]  tdr_q;
	logic [TDR_W-1:0]  tdr_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic              push_q;
	logic              push_d;

	// Write side of all four registers
	always_comb
	begin
		tcr_d  = tcr_q;
		iti_d  = iti_q;
		ito_d  = ito_q;
		tdr_d  = tdr_q;
		push_d = 1'b0;
		if (access_wr)
		begin
			if (hit(paddr, OFS_TEST_CONTROL))
				tcr_d = pwdata[TCR_W-1:0];
			if (hit(paddr, OFS_INTEG_INPUT))
				// Only the DMA clear bits store; pin bits are read-only
				iti_d = pwdata[ITI_TXCLR_BIT:ITI_RXCLR_BIT];
			if (hit(paddr, OFS_INTEG_OUTPUT))
				ito_d = pwdata[ITO_W-1:0];
			if (hit(paddr, OFS_FIFO_TEST))
			begin
				tdr_d  = pwdata[TDR_W-1:0];
				push_d = tcr_q[TCR_FIFO_BIT];
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			tcr_q  <= TCR_RST;
			iti_q  <= ITI_RST;
			ito_q  <= ITO_RST;
			tdr_q  <= TDR_RST;
			push_q <= 1'b0;
		end
		else
		begin
			tcr_q  <= tcr_d;
			iti_q  <= iti_d;
			ito_q  <= ito_d;
			tdr_q  <= tdr_d;
			push_q <= push_d;
		end
	end

	// Mode levels
	assign integration_test_enable = tcr_q[TCR_INTEGRATION_TEST_ENABLE_BIT];
	assign fifo_test_enable        = tcr_q[TCR_FIFO_BIT];
	assign infrared_test_enable    = tcr_q[TCR_IRTST_BIT];

	// Half-duplex unless infrared test is set; loopback itself lives in
	// the main control register, which software must also set
	assign infrared_rx_enable = infrared_test_enable
		|| !infrared_tx_active;

	// DMA clear test multiplexers
	always_comb
	begin
		if (integration_test_enable)
		begin
			tx_dma_clear_int = iti_q[1];
			rx_dma_clear_int = iti_q[0];
		end
		else
		begin
			tx_dma_clear_int = tx_dma_clear;
			rx_dma_clear_int = rx_dma_clear;
		end
	end

	// Output test multiplexer; stored bits take over in test mode
	assign core_out_mux = integration_test_enable ? ito_q
		: core_out_func;

	// Pop only in the access phase so one read removes one word
	assign tx_fifo_pop = access_rd && sel_tdr
		&& fifo_test_enable;

	// Push uses the stored word one cycle after the write
	assign rx_fifo_push      = push_q;
	assign rx_fifo_push_data = tdr_q;

	// Read word of each register; reserved bits read as zero
	logic [DATA_W-1:0] word_tcr;
	logic [DATA_W-1:0] word_iti;
	logic [DATA_W-1:0] word_ito;
	logic [DATA_W-1:0] word_tdr;

	always_comb
	begin
		word_tcr = '0;
		word_iti = '0;
		word_ito = '0;
		word_tdr = '0;
		word_tcr[TCR_W-1:0] = tcr_q;
		word_iti[ITI_TXCLR_BIT] = tx_dma_clear_int;
		word_iti[ITI_RXCLR_BIT] = rx_dma_clear_int;
		word_iti[ITI_PIN_HI:0]  = sync_if.pins_sync;
		// Intra-chip bits read at the mux output
		word_ito[ITO_W-1:0] = {core_out_mux[ITO_W-1:ITO_INTRA_LO],
			ito_q[ITO_INTRA_LO-1:0]};
		if (fifo_test_enable)
			word_tdr[TDR_W-1:0] = tx_fifo_head;
		else
			word_tdr[TDR_W-1:0] = tdr_q;
	end

	// Read data is captured in the setup phase; the FIFO head is valid
	// then and is only popped in the following access phase. It holds
	// through the access phase and returns to zero once psel drops.
	always_comb
	begin
		rdata_d = '0;
		if (setup_rd)
		begin
			if (sel_tcr)
				rdata_d = word_tcr;
			else if (sel_iti)
				rdata_d = word_iti;
			else if (sel_ito)
				rdata_d = word_ito;
			else if (sel_tdr)
				rdata_d = word_tdr;
		end
		else if (psel)
			rdata_d = rdata_q;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			rdata_q <= '0;
		else
			rdata_q <= rdata_d;
	end

	assign prdata = rdata_q;

endmodule

// ---- tb/uit_test_regs_properties.sv ----
// Purpose: Port-level properties of the UART test register block
// Assumes: Aligned register addresses on the peripheral bus
// Notes:   Bound to every instance of the block top
`timescale 1ns/1ps
module uit_test_regs_properties
	import uit_pkg::*;
(
	input wire logic		core_clk,
	input wire logic		nrst,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [ADDR_W-1:0]	paddr,
	input wire logic [DATA_W-1:0]	pwdata,
	input wire logic		tx_dma_clear,
	input wire logic		tx_dma_clear_int,
	input wire logic		infrared_tx_active,
	input wire logic		infrared_rx_enable,
	input wire logic		integration_test_enable,
	input wire logic		fifo_test_enable,
	input wire logic		infrared_test_enable,
	input wire logic		rx_fifo_push,
	input wire logic [TDR_W-1:0]	rx_fifo_push_data,
	input wire logic		tx_fifo_pop
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire wr_acc = psel & penable & pwrite;
	wire wr_tcr = wr_acc & (paddr == OFS_TEST_CONTROL);
	property p_dma;
		!integration_test_enable |-> tx_dma_clear_int == tx_dma_clear;
	endproperty
	property p_irrx;
		infrared_rx_enable == (infrared_test_enable | !infrared_tx_active);
	endproperty
	property p_push;
		rx_fifo_push |->
			$past(wr_acc && fifo_test_enable && paddr == OFS_FIFO_TEST);
	endproperty
	property p_nopush;
		$past(!fifo_test_enable) |-> !rx_fifo_push;
	endproperty
	property p_data;
		rx_fifo_push |-> rx_fifo_push_data == $past(pwdata[10:0]);
	endproperty
	property p_pop;
		tx_fifo_pop |-> psel && penable && !pwrite && fifo_test_enable
			&& paddr == OFS_FIFO_TEST;
	endproperty
	property p_mode;
		!$past(wr_tcr) |-> $stable({integration_test_enable,
			fifo_test_enable, infrared_test_enable});
	endproperty
	property p_integration_test_enable;
		$past(wr_tcr) |-> integration_test_enable == $past(pwdata[0]);
	endproperty
	a_dma: assert property (p_dma) else $error("dma clear bypass");
	a_irrx: assert property (p_irrx) else $error("ir rx gate");
	a_push: assert property (p_push) else $error("stray push");
	a_nopush: assert property (p_nopush) else $error("push off");
	a_data: assert property (p_data) else $error("push word");
	a_pop: assert property (p_pop) else $error("stray pop");
	a_mode: assert property (p_mode) else $error("mode moved");
	a_integration_test_enable: assert property (p_integration_test_enable) else $error("integration_test_enable write");
	c_push: cover property (rx_fifo_push);
	c_pop: cover property (tx_fifo_pop);
	c_ovr: cover property (integration_test_enable && tx_dma_clear_int);
endmodule
bind uit_test_regs uit_test_regs_properties chk_u
(
	.core_clk                (core_clk),
	.nrst                    (nrst),
	.psel                    (psel),
	.penable                 (penable),
	.pwrite                  (pwrite),
	.paddr                   (paddr),
	.pwdata                  (pwdata),
	.tx_dma_clear            (tx_dma_clear),
	.tx_dma_clear_int        (tx_dma_clear_int),
	.infrared_tx_active      (infrared_tx_active),
	.infrared_rx_enable      (infrared_rx_enable),
	.integration_test_enable (integration_test_enable),
	.fifo_test_enable        (fifo_test_enable),
	.infrared_test_enable    (infrared_test_enable),
	.rx_fifo_push            (rx_fifo_push),
	.rx_fifo_push_data       (rx_fifo_push_data),
	.tx_fifo_pop             (tx_fifo_pop)
);

// ---- tb/uit_fifo_model.sv ----
// Purpose: Transmit FIFO head seen by the test data path
// Assumes: One word leaves per pop pulse
// Notes:   Words follow a fixed stride so the bench can predict them
`timescale 1ns/1ps
module uit_fifo_model
	import uit_pkg::*;
(
	input  wire logic		core_clk,
	input  wire logic		nrst,
	input  wire logic		tx_fifo_pop,
	output logic [TDR_W-1:0]	tx_fifo_head
);
	logic [TDR_W-1:0] head_q;
	logic [TDR_W-1:0] head_d;
	always_comb head_d = tx_fifo_pop ? head_q + 11'h0A3 : head_q;
	always_ff @(posedge core_clk) head_q <= nrst ? head_d : 11'h155;
	assign tx_fifo_head = head_q;
endmodule

// ---- tb/tb_uit_test_regs.sv ----
// Purpose: Self-checking bench for the UART test registers
// Assumes: Setup then access bus cycles with no waits
// Notes:   Random modes, data and pin levels each round
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin \
	err_count++; $display("FAIL %s exp %h got %h", n, e, s); end end
module tb_uit_test_regs;
	import uit_pkg::*;
	logic core_clk, nrst, psel, penable, pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd, tcr, iti, ito, tdr;
	logic ring_indicator_n, carrier_detect_n, clear_to_send_n;
	logic data_set_ready_n, infrared_serial_in, serial_receive_data;
	logic [5:0] pins;
	logic tx_dma_clear, rx_dma_clear, tx_dma_clear_int, rx_dma_clear_int;
	logic [ITO_W-1:0] core_out_func, core_out_mux;
	logic infrared_tx_active, infrared_rx_enable;
	logic integration_test_enable, fifo_test_enable, infrared_test_enable;
	logic rx_fifo_push, tx_fifo_pop;
	logic [TDR_W-1:0] rx_fifo_push_data, tx_fifo_head;
	int err_count, num_checks, pushes, npush, seed, head;
	logic [TDR_W-1:0] rxq[$];
	logic [TDR_W-1:0] exp_push;
	assign {ring_indicator_n, carrier_detect_n, clear_to_send_n,
		data_set_ready_n, infrared_serial_in, serial_receive_data} = pins;
	uit_test_regs dut_u (.*);
	uit_fifo_model fifo_u (.*);
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		if (rx_fifo_push === 1'b1)
		begin
			pushes++;
			exp_push = (rxq.size() > 0) ? rxq.pop_front() : 'x;
			`CHK("push data", exp_push, rx_fifo_push_data);
		end
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		{psel, penable, pwrite, paddr, pwdata} = {2'b10, w, a, d};
		@(posedge core_clk);
		#1 penable = 1'b1;
		@(posedge core_clk);
		rd = prdata;
		#1 {psel, penable} = 2'b00;
		// Idle cycle so the next call never re-raises psel in the same
		// time step, and read data falls back to zero in between
		@(posedge core_clk);
		#1;
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#100000 err_count++;
		give_verdict();
	end
	initial
	begin
		{nrst, psel, penable, pwrite, paddr, pwdata, pins} = '0;
		{tx_dma_clear, rx_dma_clear, infrared_tx_active} = '0;
		core_out_func = '0;
		{err_count, num_checks, pushes, npush} = '0;
		seed = 32'h257f;
		head = 'h155;
		repeat (8) @(posedge core_clk);
		#1 nrst = 1'b1;
		// Last offset is unmapped and must read zero
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b0, 12'h080 + 12'(4 * i), '0);
			`CHK("reset", 32'h0, rd);
		end
		repeat (40)
		begin
			{tcr, iti, ito, tdr} = {$random(seed), $random(seed),
				$random(seed), $random(seed)};
			{pins, tx_dma_clear, rx_dma_clear, infrared_tx_active} =
				9'($random(seed));
			core_out_func = 14'($random(seed));
			bus(1'b1, OFS_TEST_CONTROL, tcr);
			bus(1'b1, OFS_INTEG_INPUT, iti);
			bus(1'b1, OFS_INTEG_OUTPUT, ito);
			// Queue before the write: the push shows at the next edge
			if (tcr[1])
				rxq.push_back(tdr[10:0]);
			bus(1'b1, OFS_FIFO_TEST, tdr);
			bus(1'b1, 12'h090, '1);
			npush += tcr[1];
			`CHK("mode", tcr[2:0], {infrared_test_enable,
				fifo_test_enable, integration_test_enable});
			`CHK("irrx", tcr[2] | ~infrared_tx_active,
				infrared_rx_enable);
			`CHK("mux", tcr[0] ? ito[13:0] : core_out_func,
				core_out_mux);
			`CHK("dma clear", tcr[0] ? iti[7:6] : {tx_dma_clear,
				rx_dma_clear}, {tx_dma_clear_int, rx_dma_clear_int});
			bus(1'b0, OFS_TEST_CONTROL, '0);
			`CHK("tcr", tcr[2:0], rd);
			bus(1'b0, OFS_INTEG_INPUT, '0);
			`CHK("iti", {24'h0, tcr[0] ? iti[7:6] :
				{tx_dma_clear, rx_dma_clear}, pins}, rd);
			bus(1'b0, OFS_INTEG_OUTPUT, '0);
			`CHK("ito", {18'h0, tcr[0] ? ito[13:6] :
				core_out_func[13:6], ito[5:0]}, rd);
			bus(1'b0, OFS_FIFO_TEST, '0);
			`CHK("tdr", tcr[1] ? head[10:0] : tdr[10:0], rd);
			if (tcr[1])
				head = (head + 'hA3) & 'h7FF;
			bus(1'b0, 12'h090, '0);
			`CHK("unmapped", 32'h0, rd);
			`CHK("pushes", npush, pushes);
		end
		#1 nrst = 1'b0;
		repeat (2) @(posedge core_clk);
		#1 nrst = 1'b1;
		bus(1'b0, OFS_TEST_CONTROL, '0);
		`CHK("rst2", 32'h0, rd);
		give_verdict();
	end
endmodule
